// ### inc/rdc_pkg.sv
// Constants, register map and state types of the ring drive control and status block.
// Assumes a 250 MHz APB clock and a receiver front end that delivers decoded telegrams.
//
// Notes on behaviour
// - A written node address takes effect only at the next phase step 0 to 1.
// - Node address comes only from the configured value, not the ring position.
// - Cable length maps to four power levels: 15 m, 30 m, 45 m, beyond.
// - Line rate 2/4/8/16 MBaud is detected automatically and readable.
// - Distortion indicator lights on bad signal, unsupported rate or bad level.
// - Device sends one drive telegram per cycle with its status word, except in phase 0.
// - Control word bit 15 is power-on request; activation on its rising edge.
// - Power-on accepted only in phase 4, without fault, power stage on.
// - Control word bit 13 low holds the drive halted, level sensitive.
// - Status bits 15:14 go from 10 to 11 after acceptance and readiness.
// - Withdrawal is acknowledged after the stopping reaction delay.
// - Holding brake released not before the acknowledge rising edge.
// - Request to acknowledge delay is about 8 ms or 300 ms, readable.
// - Last received control word and sent status word are readable.
// - Shared data telegram contents apply at one common instant.
// - Sync and data telegrams are checked; each type has a failure counter.
// - Sync counter clears on phase 2 to 3, data counter on 3 to 4.
// - A fatal fault drops to phase 0 and stops drive telegrams.

package rdc_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] RDC_ADDR_NODE = 8'h00;
   localparam logic [7:0] RDC_ADDR_LEN = 8'h04;
   localparam logic [7:0] RDC_ADDR_BAUD = 8'h08;
   localparam logic [7:0] RDC_ADDR_CTRLW = 8'h0c;
   localparam logic [7:0] RDC_ADDR_STATW = 8'h10;
   localparam logic [7:0] RDC_ADDR_ERRCNT = 8'h14;
   localparam logic [7:0] RDC_ADDR_DELAY = 8'h18;
   localparam logic [7:0] RDC_ADDR_DRV = 8'h1c;
   localparam logic [7:0] RDC_ADDR_PHASE = 8'h20;

   // ****************************************
   // Field positions and values
   // ****************************************
   localparam int RDC_BIT_REQ = 15;
   localparam int RDC_BIT_HALT = 13;
   localparam logic [1:0] RDC_ST_READY = 2'h2;
   localparam logic [1:0] RDC_ST_RUN = 2'h3;
   localparam logic [2:0] RDC_PH_RUN = 3'h4;
   localparam logic [7:0] RDC_LEN_L1 = 8'h0f;
   localparam logic [7:0] RDC_LEN_L2 = 8'h1e;
   localparam logic [7:0] RDC_LEN_L3 = 8'h2d;
   localparam logic [7:0] RDC_NODE_RST = 8'h00;
   localparam logic [7:0] RDC_LEN_RST = 8'h00;
   localparam logic [1:0] RDC_BAUD_2 = 2'h0;
   localparam logic [1:0] RDC_BAUD_16 = 2'h3;

   // ****************************************
   // Timing
   // ****************************************
   localparam int RDC_CLK_MHZ = 250;
   localparam int RDC_T_SYNC_MS = 8;
   localparam int RDC_T_ASYNC_MS = 300;
   localparam int RDC_T_STOP_MS = 8;
   localparam int RDC_CYC_SYNC = RDC_T_SYNC_MS * RDC_CLK_MHZ * 1000;
   localparam int RDC_CYC_ASYNC = RDC_T_ASYNC_MS * RDC_CLK_MHZ * 1000;
   localparam int RDC_CYC_STOP = RDC_T_STOP_MS * RDC_CLK_MHZ * 1000;

   typedef enum logic [1:0]
   {
      RDC_OFF = 2'b00,
      RDC_ON_WAIT = 2'b01,
      RDC_ON = 2'b10,
      RDC_OFF_WAIT = 2'b11
   } rdc_drv_e;

endpackage

// ### src/rdc_power_level.sv
// Maps the outgoing cable length in metres to a transmitter power level.
// Assumes the length is a stable register value.
`timescale 1ns/1ps
module rdc_power_level
   import rdc_pkg::*;
(
   input wire logic [7:0] cable_len,
   input wire logic glass_fibre,
   output logic [1:0] tx_level
);

   always_comb
   begin
      if (glass_fibre || cable_len > RDC_LEN_L3)
         tx_level = 2'h3;
      else if (cable_len > RDC_LEN_L2)
         tx_level = 2'h2;
      else if (cable_len > RDC_LEN_L1)
         tx_level = 2'h1;
      else
         tx_level = 2'h0;
   end

endmodule // rdc_power_level

// ### src/rdc_baud_detect.sv
// Detects the line rate from the shortest pulse on the optical receive pin.
// Assumes rx_pin is asynchronous; it is synchronised here first.
`timescale 1ns/1ps
module rdc_baud_detect
   import rdc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rx_pin,
   output logic [1:0] baud_sel,
   output logic baud_ok
);

   logic rx_m;
   logic rx_s;
   logic rx_d;
   logic [7:0] run;
   logic [7:0] next_run;
   logic [7:0] min_run;
   logic [7:0] next_min_run;
   logic [1:0] next_baud_sel;
   logic next_baud_ok;

   // Shortest run seen: 16 MBaud is about 16 cycles, 2 MBaud about 125
   always_comb
   begin
      next_run = run;
      next_min_run = min_run;
      next_baud_sel = baud_sel;
      next_baud_ok = baud_ok;
      if (rx_s != rx_d)
      begin
         next_run = 8'h01;
         if (run < min_run)
            next_min_run = run;
      end
      else if (run != 8'hff)
         next_run = run + 8'h01;
      if (min_run >= 8'h0c && min_run <= 8'h14)
      begin
         next_baud_sel = RDC_BAUD_16;
         next_baud_ok = 1'b1;
      end
      else if (min_run >= 8'h1a && min_run <= 8'h26)
      begin
         next_baud_sel = 2'h2;
         next_baud_ok = 1'b1;
      end
      else if (min_run >= 8'h36 && min_run <= 8'h4a)
      begin
         next_baud_sel = 2'h1;
         next_baud_ok = 1'b1;
      end
      else if (min_run >= 8'h6e && min_run <= 8'h8c)
      begin
         next_baud_sel = RDC_BAUD_2;
         next_baud_ok = 1'b1;
      end
      else if (min_run != 8'hff)
         next_baud_ok = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_m <= 1'b0;
         rx_s <= 1'b0;
         rx_d <= 1'b0;
         run <= 8'h00;
         min_run <= 8'hff;
         baud_sel <= RDC_BAUD_2;
         baud_ok <= 1'b0;
      end
      else
      begin
         rx_m <= rx_pin;
         rx_s <= rx_m;
         rx_d <= rx_s;
         run <= next_run;
         min_run <= next_min_run;
         baud_sel <= next_baud_sel;
         baud_ok <= next_baud_ok;
      end
   end

endmodule // rdc_baud_detect

// ### src/rdc_ring_drive.sv
// Drive side of the cyclic ring link: telegram handling, enable sequence, APB registers.
// Assumes a receiver front end on pclk delivering checked sync and data telegrams,
// and a transmitter that sends the drive telegram on at_send_req.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module rdc_ring_drive
   import rdc_pkg::*;
#(
   parameter int CYC_SYNC = RDC_CYC_SYNC,
   parameter int CYC_ASYNC = RDC_CYC_ASYNC,
   parameter int CYC_STOP = RDC_CYC_STOP
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   input wire logic signal_fault,
   input wire logic level_fault,
   input wire logic sync_valid,
   input wire logic sync_bad,
   input wire logic [2:0] sync_phase,
   input wire logic data_valid,
   input wire logic data_bad,
   input wire logic [15:0] data_ctrl,
   input wire logic cycle_strobe,
   input wire logic fatal_fault,
   input wire logic drive_fault,
   input wire logic power_on,
   output logic [1:0] baud_sel,
   output logic [1:0] tx_level,
   output logic [7:0] node_addr,
   output logic distortion_indicator,
   output logic at_send_req,
   output logic [15:0] at_status,
   output logic halted,
   output logic energize,
   output logic brake_release
);

   // ****************************************
   // Register file
   // ****************************************
   logic [7:0] node_cfg;
   logic [7:0] next_node_cfg;
   logic [7:0] cable_len;
   logic [7:0] next_cable_len;
   logic glass;
   logic next_glass;
   logic async_motor;
   logic next_async_motor;
   logic [31:0] next_prdata;
   logic baud_ok;
   logic wr;

   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;

   // ****************************************
   // Cycle and drive state
   // ****************************************
   logic [2:0] phase;
   logic [2:0] next_phase;
   logic [7:0] next_node_addr;
   logic [15:0] ctrl_hold;
   logic [15:0] next_ctrl_hold;
   logic [15:0] ctrl_word;
   logic [15:0] next_ctrl_word;
   logic req_prev;
   logic next_req_prev;
   logic [7:0] sync_errs;
   logic [7:0] next_sync_errs;
   logic [7:0] data_errs;
   logic [7:0] next_data_errs;
   logic [15:0] next_at_status;
   logic next_at_send_req;
   logic next_brake_release;
   logic next_halted;
   rdc_drv_e drv;
   rdc_drv_e next_drv;
   logic [31:0] tmr;
   logic [31:0] next_tmr;
   logic [31:0] on_delay;
   logic [31:0] last_delay;
   logic [31:0] next_last_delay;
   logic req_rise;
   logic req_now;

   assign on_delay = async_motor ? CYC_ASYNC : CYC_SYNC;
   assign req_now = ctrl_word[RDC_BIT_REQ];
   assign req_rise = req_now && !req_prev;

   rdc_baud_detect u_baud
   (
      .pclk(pclk),
      .presetn(presetn),
      .rx_pin(rx_pin),
      .baud_sel(baud_sel),
      .baud_ok(baud_ok)
   );

   rdc_power_level u_level
   (
      .cable_len(cable_len),
      .glass_fibre(glass),
      .tx_level(tx_level)
   );

   always_comb
   begin
      next_node_cfg = node_cfg;
      next_cable_len = cable_len;
      next_glass = glass;
      next_async_motor = async_motor;
      next_prdata = prdata;
      pslverr = 1'b0;
      // Read data loads at the setup edge, so it stands at the access edge
      if (psel)
      begin
         if (paddr == RDC_ADDR_NODE)
         begin
            if (wr)
               next_node_cfg = pwdata[7:0];
            next_prdata = {16'h0000, node_addr, node_cfg};
         end
         else if (paddr == RDC_ADDR_LEN)
         begin
            if (wr)
            begin
               next_cable_len = pwdata[7:0];
               next_glass = pwdata[8];
            end
            next_prdata = {20'h00000, tx_level, 1'b0, glass, cable_len};
         end
         else if (paddr == RDC_ADDR_BAUD)
            next_prdata = {29'h00000000, baud_ok, baud_sel};
         else if (paddr == RDC_ADDR_CTRLW)
            next_prdata = {16'h0000, ctrl_word};
         else if (paddr == RDC_ADDR_STATW)
            next_prdata = {16'h0000, at_status};
         else if (paddr == RDC_ADDR_ERRCNT)
            next_prdata = {16'h0000, data_errs, sync_errs};
         else if (paddr == RDC_ADDR_DELAY)
         begin
            if (wr)
               next_async_motor = pwdata[0];
            next_prdata = last_delay;
         end
         else if (paddr == RDC_ADDR_DRV)
            next_prdata = {27'h0000000, async_motor, brake_release, energize, drv};
         else if (paddr == RDC_ADDR_PHASE)
            next_prdata = {29'h00000000, phase};
         else
         begin
            next_prdata = 32'h00000000;
            pslverr = penable;
         end
      end
   end

   always_comb
   begin
      next_phase = phase;
      next_node_addr = node_addr;
      next_ctrl_hold = ctrl_hold;
      next_ctrl_word = ctrl_word;
      next_req_prev = req_prev;
      next_sync_errs = sync_errs;
      next_data_errs = data_errs;
      next_at_send_req = 1'b0;
      next_drv = drv;
      next_tmr = tmr;
      next_last_delay = last_delay;
      next_halted = halted;
      next_brake_release = brake_release;
      if (fatal_fault)
         next_phase = 3'h0;
      else if (sync_valid)
      begin
         next_phase = sync_phase;
         if (phase == 3'h0 && sync_phase == 3'h1)
            next_node_addr = node_cfg;
      end
      if (sync_valid && phase == 3'h2 && sync_phase == 3'h3)
         next_sync_errs = 8'h00;
      else if (sync_bad && sync_errs != 8'hff)
         next_sync_errs = sync_errs + 8'h01;
      if (sync_valid && phase == 3'h3 && sync_phase == 3'h4)
         next_data_errs = 8'h00;
      else if (data_bad && data_errs != 8'hff)
         next_data_errs = data_errs + 8'h01;
      if (data_valid)
         next_ctrl_hold = data_ctrl;
      if (cycle_strobe)
      begin
         next_ctrl_word = ctrl_hold;
         next_req_prev = ctrl_word[RDC_BIT_REQ];
         next_halted = !ctrl_hold[RDC_BIT_HALT];
         next_at_send_req = !fatal_fault && phase != 3'h0;
      end
      // is the master's; the sequence does not depend on it
      case (drv)
         RDC_OFF:
         begin
            next_brake_release = 1'b0;
            if (cycle_strobe && req_rise && phase == RDC_PH_RUN && !drive_fault && power_on)
            begin
               next_drv = RDC_ON_WAIT;
               next_tmr = 32'h00000000;
            end
         end
         RDC_ON_WAIT:
         begin
            next_tmr = tmr + 32'h00000001;
            if (!req_now || drive_fault || !power_on)
               next_drv = RDC_OFF;
            else if (tmr >= on_delay - 1)
            begin
               next_drv = RDC_ON;
               next_last_delay = tmr + 32'h00000001;
            end
         end
         RDC_ON:
         begin
            next_brake_release = 1'b1;
            if (!req_now || drive_fault || !power_on || phase != RDC_PH_RUN)
            begin
               next_drv = RDC_OFF_WAIT;
               next_brake_release = 1'b0;
               next_tmr = 32'h00000000;
            end
         end
         default:
         begin
            next_brake_release = 1'b0;
            next_tmr = tmr + 32'h00000001;
            if (tmr >= CYC_STOP - 1)
               next_drv = RDC_OFF;
         end
      endcase
   end

   always_comb
   begin
      next_at_status = 16'h0000;
      if (power_on && !drive_fault)
      begin
         if (drv == RDC_ON || drv == RDC_OFF_WAIT)
            next_at_status[15:14] = RDC_ST_RUN;
         else
            next_at_status[15:14] = RDC_ST_READY;
      end
      next_at_status[13] = drive_fault;
      next_at_status[2:0] = phase;
   end

   assign energize = drv != RDC_OFF;
   assign distortion_indicator = signal_fault || level_fault || !baud_ok;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         node_cfg <= RDC_NODE_RST;
         cable_len <= RDC_LEN_RST;
         glass <= 1'b0;
         async_motor <= 1'b0;
         prdata <= 32'h00000000;
         phase <= 3'h0;
         node_addr <= RDC_NODE_RST;
         ctrl_hold <= 16'h0000;
         ctrl_word <= 16'h0000;
         req_prev <= 1'b0;
         sync_errs <= 8'h00;
         data_errs <= 8'h00;
         at_status <= 16'h0000;
         at_send_req <= 1'b0;
         drv <= RDC_OFF;
         tmr <= 32'h00000000;
         last_delay <= 32'h00000000;
         halted <= 1'b1;
         brake_release <= 1'b0;
      end
      else
      begin
         node_cfg <= next_node_cfg;
         cable_len <= next_cable_len;
         glass <= next_glass;
         async_motor <= next_async_motor;
         prdata <= next_prdata;
         phase <= next_phase;
         node_addr <= next_node_addr;
         ctrl_hold <= next_ctrl_hold;
         ctrl_word <= next_ctrl_word;
         req_prev <= next_req_prev;
         sync_errs <= next_sync_errs;
         data_errs <= next_data_errs;
         at_status <= next_at_status;
         at_send_req <= next_at_send_req;
         drv <= next_drv;
         tmr <= next_tmr;
         last_delay <= next_last_delay;
         halted <= next_halted;
         brake_release <= next_brake_release;
      end
   end

endmodule // rdc_ring_drive

// ### tb/rdc_ring_drive_assertions.sv
// Port checks of the ring drive block, bound into rdc_ring_drive.
// Assumes one pclk domain and presetn asynchronous, active low.
`timescale 1ns/1ps
module rdc_ring_drive_assertions
   import rdc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cycle_strobe,
   input wire logic fatal_fault,
   input wire logic drive_fault,
   input wire logic power_on,
   input wire logic signal_fault,
   input wire logic level_fault,
   input wire logic at_send_req,
   input wire logic [15:0] at_status,
   input wire logic halted,
   input wire logic energize,
   input wire logic brake_release,
   input wire logic distortion_indicator
);
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_send_after_strobe:
      assert property (at_send_req |-> $past(cycle_strobe))
      else $error("drive telegram without cycle strobe");
   chk_send_single:
      assert property (at_send_req |=> !at_send_req)
      else $error("drive telegram request longer than one cycle");
   chk_fatal_silent:
      assert property (cycle_strobe && fatal_fault |=> !at_send_req)
      else $error("drive telegram sent during fatal fault");
   chk_brake_after_ack:
      assert property ($rose(brake_release) |-> at_status[15:14] == RDC_ST_RUN)
      else $error("brake released before acknowledge");
   chk_halt_at_strobe:
      assert property (!$stable(halted) |-> $past(cycle_strobe) || $past(cycle_strobe, 2))
      else $error("halt changed away from the cycle instant");
   chk_energize_cond:
      assert property ($rose(energize) |-> $past(power_on) && !$past(drive_fault))
      else $error("energized without preconditions");
   chk_distortion_lit:
      assert property (signal_fault || level_fault |-> distortion_indicator)
      else $error("indicator dark on receive fault");
   chk_ack_delay:
      assert property ($rose(energize) |=> (at_status[15:14] != RDC_ST_RUN) [*8])
      else $error("acknowledge came too early");
   chk_ack_needs_on:
      assert property ($rose(at_status[14]) |-> at_status[15] && energize)
      else $error("acknowledge without accepted request");
endmodule // rdc_ring_drive_assertions

bind rdc_ring_drive rdc_ring_drive_assertions rdc_ring_drive_assertions_inst (.pclk, .presetn,
   .cycle_strobe, .fatal_fault, .drive_fault, .power_on, .signal_fault, .level_fault,
   .at_send_req, .at_status, .halted, .energize, .brake_release, .distortion_indicator);

// ### tb/rdc_master_model.sv
// Ring master model: sync, data telegram and cycle strobe every 8 clocks.
// Assumes the bench sets phase, control word and corrupt flags.
`timescale 1ns/1ps
module rdc_master_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] phase,
   input wire logic [15:0] ctrl,
   input wire logic [1:0] corrupt,
   output logic sync_valid,
   output logic sync_bad,
   output logic [2:0] sync_phase,
   output logic data_valid,
   output logic data_bad,
   output logic [15:0] data_ctrl,
   output logic cycle_strobe
);
   logic [2:0] slot;

   // ****************************************
   // Telegram slots
   // ****************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot <= 3'h0;
         {sync_valid, sync_bad, data_valid, data_bad, cycle_strobe} <= 5'h00;
         sync_phase <= 3'h0;
         data_ctrl <= 16'h0000;
      end
      else
      begin
         slot <= slot + 3'h1;
         sync_valid <= slot == 3'h0 && !corrupt[0];
         sync_bad <= slot == 3'h0 && corrupt[0];
         // Fields show garbage outside their pulse
         sync_phase <= (slot == 3'h0) ? phase : ~sync_phase;
         data_valid <= slot == 3'h2 && !corrupt[1];
         data_bad <= slot == 3'h2 && corrupt[1];
         data_ctrl <= (slot == 3'h2) ? ctrl : ~data_ctrl;
         cycle_strobe <= slot == 3'h4;
      end
   end
endmodule // rdc_master_model

// ### tb/rdc_ring_drive_tb.sv
// Self-checking bench of the ring drive block over APB and the master model.
// Assumes shortened on and off delays; a bus cycle is 8 clocks.
`timescale 1ns/1ps
module rdc_ring_drive_tb
   import rdc_pkg::*;
;
   localparam int T_ON = 20;
   localparam int T_SLOW = 50;
   localparam int T_STOP = 10;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic rx_pin = 1'b0, signal_fault = 1'b0, level_fault = 1'b0, fatal_fault = 1'b0;
   logic drive_fault = 1'b0, power_on = 1'b1, pready, pslverr, err;
   logic [7:0] paddr = 8'h00, node_addr;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [2:0] phase = 3'h0, sync_phase;
   logic [15:0] ctrl = 16'h2000, data_ctrl, at_status;
   logic [1:0] corrupt = 2'h0, baud_sel, tx_level;
   logic sync_valid, sync_bad, data_valid, data_bad, cycle_strobe, distortion_indicator;
   logic at_send_req, halted, energize, brake_release;
   int fails = 0, n_tests = 0, k;
   logic [7:0] lens [6] = '{8'h0f, 8'h10, 8'h1e, 8'h1f, 8'h2d, 8'h2e};
   int bits [4] = '{125, 63, 31, 16};

   always #2 pclk = ~pclk;

   rdc_ring_drive #(.CYC_SYNC(T_ON), .CYC_ASYNC(T_SLOW), .CYC_STOP(T_STOP)) rdc_ring_drive_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .rx_pin, .signal_fault, .level_fault, .sync_valid, .sync_bad, .sync_phase, .data_valid,
      .data_bad, .data_ctrl, .cycle_strobe, .fatal_fault, .drive_fault, .power_on, .baud_sel,
      .tx_level, .node_addr, .distortion_indicator, .at_send_req, .at_status, .halted,
      .energize, .brake_release);
   rdc_master_model rdc_master_model_inst (.pclk, .presetn, .phase, .ctrl, .corrupt,
      .sync_valid, .sync_bad, .sync_phase, .data_valid, .data_bad, .data_ctrl, .cycle_strobe);

   // ****************************************
   // Tasks
   // ****************************************
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Read data and error are taken at the edge where pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      err = pslverr;
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 50)
      begin
         fails++;
         summarize();
      end
   endtask

   task automatic ncyc(input int c);
      repeat (8 * c) @(posedge pclk);
   endtask

   // Status 0 means wait for energize
   task automatic wait_for(input logic [1:0] st, output int n);
      n = 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while ((st == 2'h0 ? energize !== 1'b1 : at_status[15:14] !== st) && n < 400);
      @(posedge pclk);
      if (n >= 400)
      begin
         fails++;
         summarize();
      end
   endtask

   task automatic sends(output int c);
      c = 0;
      repeat (32)
      begin
         @(negedge pclk);
         c += int'(at_send_req === 1'b1);
      end
      @(posedge pclk);
   endtask

   task automatic enable_run(input int min_on);
      int n;
      ctrl <= 16'ha000;
      wait_for(2'h0, n);
      wait_for(RDC_ST_RUN, n);
      chk("on delay", 32'(n >= min_on), 32'h1);
      repeat (2) @(posedge pclk);
      chk("brake", 32'(brake_release), 32'h1);
      apb(1'b0, RDC_ADDR_STATW, 32'h0, r);
      chk("status run", 32'(r[15:14]), 32'h3);
      apb(1'b0, RDC_ADDR_CTRLW, 32'h0, r);
      chk("ctrl copy", r, 32'ha000);
      ctrl <= 16'h2000;
      wait_for(RDC_ST_READY, n);
      chk("off delay", 32'(n >= T_STOP), 32'h1);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h40, 32'h0, r);
      chk("slverr", 32'(err), 32'h1);
      chk("unmapped", r, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, RDC_ADDR_LEN, 32'(lens[i]), r);
         chk("tx_level", 32'(tx_level), 32'((i + 1) / 2));
      end
      $display("done: power levels");
      for (int b = 0; b < 4; b++)
      begin
         repeat (24)
         begin
            repeat (bits[b]) @(posedge pclk);
            rx_pin <= ~rx_pin;
         end
         chk("baud_sel", 32'(baud_sel), b);
      end
      apb(1'b0, RDC_ADDR_BAUD, 32'h0, r);
      chk("baud reg", r, 32'h7);
      chk("dark", 32'(distortion_indicator), 32'h0);
      level_fault <= 1'b1;
      @(posedge pclk);
      chk("level lit", 32'(distortion_indicator), 32'h1);
      level_fault <= 1'b0;
      signal_fault <= 1'b1;
      @(posedge pclk);
      chk("signal lit", 32'(distortion_indicator), 32'h1);
      signal_fault <= 1'b0;
      $display("done: baud and indicator");
      apb(1'b1, RDC_ADDR_NODE, 32'h5, r);
      ncyc(2);
      chk("node held", 32'(node_addr), 32'h0);
      phase <= 3'h1;
      ncyc(2);
      chk("node active", 32'(node_addr), 32'h5);
      phase <= 3'h2;
      ncyc(1);
      corrupt <= 2'h1;
      ncyc(1);
      corrupt <= 2'h0;
      ncyc(1);
      apb(1'b0, RDC_ADDR_ERRCNT, 32'h0, r);
      chk("sync errs", r, 32'h1);
      phase <= 3'h3;
      corrupt <= 2'h2;
      ncyc(1);
      corrupt <= 2'h0;
      ncyc(1);
      apb(1'b0, RDC_ADDR_ERRCNT, 32'h0, r);
      chk("data errs", r, 32'h100);
      phase <= 3'h4;
      ncyc(2);
      apb(1'b0, RDC_ADDR_ERRCNT, 32'h0, r);
      chk("errs clear", r, 32'h0);
      $display("done: address and counters");
      chk("halt off", 32'(halted), 32'h0);
      sends(k);
      chk("sends", k, 32'h4);
      enable_run(T_ON);
      apb(1'b1, RDC_ADDR_DELAY, 32'h1, r);
      enable_run(T_SLOW);
      drive_fault <= 1'b1;
      ctrl <= 16'ha000;
      ncyc(4);
      chk("fault blocks", 32'(energize), 32'h0);
      drive_fault <= 1'b0;
      ncyc(4);
      chk("edge only", 32'(energize), 32'h0);
      ctrl <= 16'h0000;
      ncyc(2);
      chk("halt on", 32'(halted), 32'h1);
      $display("done: enable sequence");
      fatal_fault <= 1'b1;
      sends(k);
      chk("fatal sends", k, 32'h0);
      apb(1'b0, RDC_ADDR_PHASE, 32'h0, r);
      chk("fatal phase", r, 32'h0);
      $display("done: fatal fault");
      summarize();
   end
endmodule // rdc_ring_drive_tb
